//--- src/drxl_lane_rx.sv
// receive data lane: escape decoding, line and start-of-transmission errors, resets and register slave
// How it works
// - escape receive clock is built from the two low-power wires
// - low-power data flag rises on data entry, holds until stop
// - each received data byte is presented with escape valid high
// - ultra-low-power flag rises on entry, holds until stop
// - triggers one-hot: reset 0001, unknown-3 0100, unknown-5 1000
// - received trigger bit holds until a stop state is seen
// - escape byte has first received bit in bit 0, moves on escape clock fall
// - soft leader error pulses for one byte-clock cycle
// - leader sync error pulses for one byte-clock cycle
// - unknown escape command raises entry error until next line change
// - data ending off a byte boundary raises sync error until next line change
// - wrong line sequence such as request then stop raises control error
// - core reset is active high in the core clock domain
// - shared logic inside gives system reset out and lock out
// - initialization-done rises once the lane finished initialization
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module drxl_lane_rx
	import drxl_pkg::*;
#(
	parameter int INIT_CYCLES = INIT_CYCLES_DEF
)(
	input wire logic clock,
	input wire logic rstn,
	input wire logic core_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic lp_dp,
	input wire logic lp_dn,
	input wire logic byte_clk,
	input wire logic sot_soft_in,
	input wire logic sot_sync_in,
	input wire logic force_reinit,
	input wire logic system_rst_in,
	input wire logic lock_in,
	output logic esc_clk,
	output logic lpdt_active,
	output logic ulps_active,
	output logic [3:0] trigger,
	output logic [7:0] esc_data,
	output logic esc_valid,
	output logic err_sot_soft,
	output logic err_sot_sync,
	output logic err_esc_entry,
	output logic err_esc_sync,
	output logic err_control,
	output logic system_rst_out,
	output logic lock_out,
	output logic init_done
);
	drxl_line_if line ();

	logic core_rst_i;
	logic lane_clr;
	logic sys_rst_eff;
	logic act_change;
	logic stop_ev;
	logic [7:0] cmd_byte;
	logic [3:0] trig_code;

	drxl_state_t st_r;
	drxl_state_t st_nxt;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic lpdt_set;
	logic ulps_set;
	logic [3:0] trig_set;
	logic esc_set;
	logic sync_set;
	logic ctl_set;
	logic byte_done;

	logic lpdt_r;
	logic ulps_r;
	logic [3:0] trig_r;
	logic [7:0] data_r;
	logic valid_r;
	logic err_soft_r;
	logic err_sync_hs_r;
	logic err_esc_r;
	logic err_syncesc_r;
	logic err_ctl_r;
	logic [INIT_CNT_W-1:0] init_cnt_r;
	logic init_done_r;
	logic sys_rst_r;
	logic lock_r;

	logic [31:0] ctrl_r;
	logic act_r;
	logic wr_r;
	logic [1:0] idx_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic hresp_r;
	logic acc;
	logic ctrl_wr;
	logic [31:0] ctrl_view;
	logic [STATUS_W-1:0] status_w;
	logic [31:0] rd_mux;

	drxl_line_frontend u_fe (
		.clock(clock),
		.rst(core_rst_i),
		.lp_dp(lp_dp),
		.lp_dn(lp_dn),
		.byte_clk(byte_clk),
		.sot_soft_in(sot_soft_in),
		.sot_sync_in(sot_sync_in),
		.force_in(force_reinit),
		.lock_in(lock_in),
		.line(line.front)
	);

	function automatic logic [1:0] reg_idx(input logic [31:0] addr);
		logic [1:0] idx;
		idx = IDX_NONE;
		if (addr == REG_CTRL_OFF) begin
			idx = IDX_CTRL;
		end else if (addr == REG_STATUS_OFF) begin
			idx = IDX_STATUS;
		end else if (addr == REG_DATA_OFF) begin
			idx = IDX_DATA;
		end
		return idx;
	endfunction

	// resets: core reset is active high beside the house active-low one
	assign core_rst_i = !rstn || core_rst;
	// shared logic in the core uses its own lock, otherwise the outside reset
	assign sys_rst_eff = ctrl_r[CTRL_SHARED_BIT] ? sys_rst_r : system_rst_in;
	// forcing only makes sense from stop; mid-burst use is the far side's fault
	assign lane_clr = core_rst_i || sys_rst_eff || line.force_lvl || ctrl_r[CTRL_FORCE_BIT];

	// line decoding is held off until the lane has initialised
	assign act_change = line.change && init_done_r;
	assign stop_ev = act_change && (line.lp == LP_STOP);
	// first bit on the line ends in bit 0
	assign cmd_byte = {line.bit_val, sh_r[7:1]};
	assign trig_code = (cmd_byte == CMD_TRIG_RESET) ? TRIG_RESET :
		(cmd_byte == CMD_TRIG_UNK3) ? TRIG_UNK3 :
		(cmd_byte == CMD_TRIG_UNK5) ? TRIG_UNK5 : TRIG_NONE;

	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		lpdt_set = 1'b0;
		ulps_set = 1'b0;
		trig_set = TRIG_NONE;
		esc_set = 1'b0;
		sync_set = 1'b0;
		ctl_set = 1'b0;
		byte_done = 1'b0;
		if (act_change) begin
			case (st_r)
				S_STOP: begin
					if (line.lp == LP_PREQ) begin
						st_nxt = S_LPREQ;
					end else if (line.lp == LP_NREQ) begin
						st_nxt = S_HSREQ;
					end else begin
						ctl_set = 1'b1;
						st_nxt = S_WAIT;
					end
				end
				S_LPREQ: begin
					if (line.lp == LP_BRIDGE) begin
						st_nxt = S_BRIDGE;
					end else begin
						ctl_set = 1'b1;
						st_nxt = S_WAIT;
					end
				end
				S_BRIDGE: begin
					// turnaround not served here, but it still owes a bridge like a high-speed request
					if (line.lp == LP_NREQ) begin
						st_nxt = S_ESCREQ;
					end else if (line.lp == LP_PREQ) begin
						st_nxt = S_HSREQ;
					end else begin
						ctl_set = 1'b1;
						st_nxt = S_WAIT;
					end
				end
				S_ESCREQ: begin
					if (line.lp == LP_BRIDGE) begin
						st_nxt = S_CMD;
						cnt_nxt = BITCNT_ZERO;
					end else begin
						ctl_set = 1'b1;
						st_nxt = S_WAIT;
					end
				end
				S_CMD, S_LPDT: begin
					if (line.bit_stb) begin
						sh_nxt = cmd_byte;
						cnt_nxt = cnt_r + 3'h1;
						if (cnt_r == BITCNT_LAST && st_r == S_LPDT) begin
							byte_done = 1'b1;
						end else if (cnt_r == BITCNT_LAST) begin
							st_nxt = S_WAIT;
							if (cmd_byte == CMD_LPDT) begin
								lpdt_set = 1'b1;
								st_nxt = S_LPDT;
							end else if (cmd_byte == CMD_ULPS) begin
								ulps_set = 1'b1;
							end else if (trig_code != TRIG_NONE) begin
								trig_set = trig_code;
							end else begin
								esc_set = 1'b1;
							end
						end
					end else if (line.lp == LP_STOP && st_r == S_LPDT && cnt_r != BITCNT_ZERO) begin
						sync_set = 1'b1;
					end
				end
				S_HSREQ: begin
					// the burst itself belongs to the high-speed path
					if (line.lp == LP_BRIDGE) begin
						st_nxt = S_WAIT;
					end else begin
						ctl_set = 1'b1;
						st_nxt = S_WAIT;
					end
				end
				S_WAIT: begin
					st_nxt = S_WAIT;
				end
				default: begin
					st_nxt = S_STOP;
				end
			endcase
			if (line.lp == LP_STOP) begin
				st_nxt = S_STOP;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (lane_clr) begin
			st_r <= S_STOP;
			sh_r <= 8'h00;
			cnt_r <= BITCNT_ZERO;
		end else begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// mode flags: a fresh entry wins over the stop that would clear it
	always_ff @(posedge clock) begin
		if (lane_clr) begin
			lpdt_r <= 1'b0;
			ulps_r <= 1'b0;
			trig_r <= TRIG_NONE;
		end else begin
			lpdt_r <= lpdt_set || (lpdt_r && !stop_ev);
			ulps_r <= ulps_set || (ulps_r && !stop_ev);
			trig_r <= (trig_set != TRIG_NONE) ? trig_set : (stop_ev ? TRIG_NONE : trig_r);
		end
	end

	// byte goes out on the escape clock fall, so it is settled at the next rise
	always_ff @(posedge clock) begin
		if (lane_clr) begin
			data_r <= 8'h00;
			valid_r <= 1'b0;
		end else if (byte_done) begin
			data_r <= cmd_byte;
			valid_r <= 1'b1;
		end else if (line.esc_fall) begin
			valid_r <= 1'b0;
		end
	end

	// line state errors hold until the next line change; a new set wins
	always_ff @(posedge clock) begin
		if (lane_clr) begin
			err_esc_r <= 1'b0;
			err_syncesc_r <= 1'b0;
			err_ctl_r <= 1'b0;
		end else begin
			err_esc_r <= esc_set || (err_esc_r && !act_change);
			err_syncesc_r <= sync_set || (err_syncesc_r && !act_change);
			err_ctl_r <= ctl_set || (err_ctl_r && !act_change);
		end
	end

	// leader errors re-sampled at each byte clock rise, so they last one byte period
	always_ff @(posedge clock) begin
		if (lane_clr) begin
			err_soft_r <= 1'b0;
			err_sync_hs_r <= 1'b0;
		end else if (line.byte_rise) begin
			err_soft_r <= line.sot_soft;
			err_sync_hs_r <= line.sot_sync;
		end
	end

	// initialization: stop must be held for the full init time
	always_ff @(posedge clock) begin
		if (lane_clr) begin
			init_cnt_r <= '0;
			init_done_r <= 1'b0;
		end else if (line.lp != LP_STOP) begin
			init_cnt_r <= '0;
		end else if (init_cnt_r == INIT_CYCLES[INIT_CNT_W-1:0]) begin
			init_done_r <= 1'b1;
		end else begin
			init_cnt_r <= init_cnt_r + INIT_CNT_W'(1);
		end
	end

	// system reset and lock only leave the block with shared logic inside
	always_ff @(posedge clock) begin
		if (core_rst_i) begin
			sys_rst_r <= 1'b1;
			lock_r <= 1'b0;
		end else begin
			sys_rst_r <= ctrl_r[CTRL_SHARED_BIT] && !line.lock_lvl;
			lock_r <= ctrl_r[CTRL_SHARED_BIT] && line.lock_lvl;
		end
	end

	// ahb-lite slave, zero wait states, always okay
	assign acc = hsel && (htrans == HTRANS_NONSEQ) && hready;
	assign ctrl_wr = act_r && wr_r && (idx_r == IDX_CTRL);
	// forward a write in flight so a read right behind it sees the new value
	assign ctrl_view = ctrl_wr ? (hwdata & CTRL_MASK) : ctrl_r;
	assign status_w = {line.lp, lock_r, err_ctl_r, err_syncesc_r, err_esc_r, trig_r, ulps_r, lpdt_r,
		init_done_r};
	assign rd_mux = (reg_idx(haddr) == IDX_CTRL) ? ctrl_view :
		(reg_idx(haddr) == IDX_STATUS) ? {{(32 - STATUS_W){1'b0}}, status_w} :
		(reg_idx(haddr) == IDX_DATA) ? {24'h000000, data_r} : 32'h00000000;

	always_ff @(posedge clock) begin
		if (core_rst_i) begin
			act_r <= 1'b0;
			wr_r <= 1'b0;
			idx_r <= IDX_NONE;
			hrdata_r <= 32'h00000000;
			ctrl_r <= CTRL_RESET;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end else begin
			act_r <= acc;
			wr_r <= hwrite && (hsize == HSIZE_WORD);
			idx_r <= reg_idx(haddr);
			hrdata_r <= (acc && !hwrite) ? rd_mux : 32'h00000000;
			ctrl_r <= ctrl_view;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign esc_clk = line.esc_clk;
	assign lpdt_active = lpdt_r;
	assign ulps_active = ulps_r;
	assign trigger = trig_r;
	assign esc_data = data_r;
	assign esc_valid = valid_r;
	assign err_sot_soft = err_soft_r;
	assign err_sot_sync = err_sync_hs_r;
	assign err_esc_entry = err_esc_r;
	assign err_esc_sync = err_syncesc_r;
	assign err_control = err_ctl_r;
	assign system_rst_out = sys_rst_r;
	assign lock_out = lock_r;
	assign init_done = init_done_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (lane_clr);

	property p_trig_onehot;
		(trig_r != TRIG_NONE) |-> $onehot(trig_r) && (trig_r[1] == 1'b0);
	endproperty
	a_trig_onehot: assert property (p_trig_onehot) else $error("trigger not one-hot");

	property p_trig_hold;
		(trig_r != TRIG_NONE) && !stop_ev && (trig_set == TRIG_NONE) |=> (trig_r == $past(trig_r));
	endproperty
	a_trig_hold: assert property (p_trig_hold) else $error("trigger dropped before stop");

	property p_lpdt_entry;
		(st_r == S_CMD) && line.bit_stb && act_change && (cnt_r == BITCNT_LAST) && (cmd_byte == CMD_LPDT)
			|=> lpdt_r && (st_r == S_LPDT);
	endproperty
	a_lpdt_entry: assert property (p_lpdt_entry) else $error("lpdt flag not raised");

	property p_ulps_stop;
		ulps_r && stop_ev |=> !ulps_r ##1 !ulps_r;
	endproperty
	a_ulps_stop: assert property (p_ulps_stop) else $error("ulps flag survived stop");

	property p_valid_byte;
		byte_done |=> esc_valid && (esc_data == $past(cmd_byte)) && lpdt_active;
	endproperty
	a_valid_byte: assert property (p_valid_byte) else $error("data byte not presented");

	property p_sot_soft;
		line.byte_rise && line.sot_soft |=> err_soft_r throughout (!line.byte_rise [*1]);
	endproperty
	a_sot_soft: assert property (p_sot_soft) else $error("soft leader error not pulsed");

	property p_sot_sync;
		$rose(err_sync_hs_r) |-> $past(line.byte_rise) && $past(line.sot_sync);
	endproperty
	a_sot_sync: assert property (p_sot_sync) else $error("sync error rose off a byte edge");

	property p_esc_hold;
		err_esc_r && !act_change |=> err_esc_r;
	endproperty
	a_esc_hold: assert property (p_esc_hold) else $error("entry error dropped early");

	property p_sync_err;
		(st_r == S_LPDT) && stop_ev && (cnt_r != BITCNT_ZERO) |=> err_syncesc_r && (st_r == S_STOP);
	endproperty
	a_sync_err: assert property (p_sync_err) else $error("partial byte not flagged");

	property p_ctl_err;
		(st_r == S_LPREQ) && stop_ev |=> err_ctl_r && !lpdt_r;
	endproperty
	a_ctl_err: assert property (p_ctl_err) else $error("request then stop not flagged");

	property p_init;
		$rose(init_done_r) |-> $past(line.lp == LP_STOP, 2);
	endproperty
	a_init: assert property (p_init) else $error("init done without stop");
endmodule

//--- src/drxl_pkg.sv
// constants, register map and state codes for the receive data lane escape and error logic
package drxl_pkg;
	// core clock and initialization timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_INIT_NS = 100000;
	localparam int INIT_CYCLES_DEF = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CNT_W = 24;

	// low-power line states as {dp, dn}
	localparam logic [1:0] LP_STOP = 2'h3;
	localparam logic [1:0] LP_PREQ = 2'h2;
	localparam logic [1:0] LP_NREQ = 2'h1;
	localparam logic [1:0] LP_BRIDGE = 2'h0;

	// escape entry commands, bit 0 is the first bit on the line
	localparam logic [7:0] CMD_LPDT = 8'h87;
	localparam logic [7:0] CMD_ULPS = 8'h78;
	localparam logic [7:0] CMD_TRIG_RESET = 8'h46;
	localparam logic [7:0] CMD_TRIG_UNK3 = 8'hba;
	localparam logic [7:0] CMD_TRIG_UNK5 = 8'h05;

	// one-hot trigger codes
	localparam logic [3:0] TRIG_NONE = 4'h0;
	localparam logic [3:0] TRIG_RESET = 4'h1;
	localparam logic [3:0] TRIG_UNK3 = 4'h4;
	localparam logic [3:0] TRIG_UNK5 = 4'h8;

	localparam logic [2:0] BITCNT_ZERO = 3'h0;
	localparam logic [2:0] BITCNT_LAST = 3'h7;

	// register map
	localparam logic [31:0] REG_CTRL_OFF = 32'h00000000;
	localparam logic [31:0] REG_STATUS_OFF = 32'h00000004;
	localparam logic [31:0] REG_DATA_OFF = 32'h00000008;
	localparam logic [1:0] IDX_CTRL = 2'h0;
	localparam logic [1:0] IDX_STATUS = 2'h1;
	localparam logic [1:0] IDX_DATA = 2'h2;
	localparam logic [1:0] IDX_NONE = 2'h3;
	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_SHARED_BIT = 1;
	localparam logic [31:0] CTRL_MASK = 32'h00000003;
	localparam logic [31:0] CTRL_RESET = 32'h00000002;
	localparam int STATUS_W = 13;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [2:0] {
		S_STOP = 3'b000,
		S_LPREQ = 3'b001,
		S_BRIDGE = 3'b010,
		S_ESCREQ = 3'b011,
		S_CMD = 3'b100,
		S_LPDT = 3'b101,
		S_WAIT = 3'b110,
		S_HSREQ = 3'b111
	} drxl_state_t;
endpackage

//--- src/drxl_line_if.sv
// synchronised line events passed from the line front end to the lane logic
`timescale 1ns/1ns
interface drxl_line_if;
	logic [1:0] lp;
	logic change;
	logic bit_stb;
	logic bit_val;
	logic esc_fall;
	logic esc_clk;
	logic byte_rise;
	logic sot_soft;
	logic sot_sync;
	logic force_lvl;
	logic lock_lvl;
	modport front (output lp, change, bit_stb, bit_val, esc_fall, esc_clk, byte_rise, sot_soft, sot_sync,
		force_lvl, lock_lvl);
	modport lane (input lp, change, bit_stb, bit_val, esc_fall, esc_clk, byte_rise, sot_soft, sot_sync,
		force_lvl, lock_lvl);
endinterface

//--- src/drxl_line_frontend.sv
// line front end: synchronisers, line transitions, escape clock and byte clock edges
`timescale 1ns/1ns
module drxl_line_frontend
	import drxl_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic lp_dp,
	input wire logic lp_dn,
	input wire logic byte_clk,
	input wire logic sot_soft_in,
	input wire logic sot_sync_in,
	input wire logic force_in,
	input wire logic lock_in,
	drxl_line_if.front line
);
	logic [1:0] lp_m_r;
	logic [1:0] lp_s_r;
	logic [1:0] lp_p_r;
	logic [2:0] bclk_r;
	logic [3:0] misc_m_r;
	logic [3:0] misc_s_r;
	logic esc_clk_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			lp_m_r <= LP_STOP;
			lp_s_r <= LP_STOP;
			lp_p_r <= LP_STOP;
			bclk_r <= 3'h0;
			misc_m_r <= 4'h0;
			misc_s_r <= 4'h0;
			esc_clk_r <= 1'b0;
		end else begin
			lp_m_r <= {lp_dp, lp_dn};
			lp_s_r <= lp_m_r;
			lp_p_r <= lp_s_r;
			bclk_r <= {bclk_r[1:0], byte_clk};
			misc_m_r <= {lock_in, force_in, sot_sync_in, sot_soft_in};
			misc_s_r <= misc_m_r;
			// escape clock rebuilt from the line pair
			esc_clk_r <= lp_s_r[1] ^ lp_s_r[0];
		end
	end

	// bits 1 and 0 are marked by which wire pulsed before the return to bridge
	assign line.lp = lp_s_r;
	assign line.change = (lp_s_r != lp_p_r);
	assign line.bit_stb = (lp_s_r == LP_BRIDGE) && ((lp_p_r == LP_PREQ) || (lp_p_r == LP_NREQ));
	assign line.bit_val = (lp_p_r == LP_PREQ);
	assign line.esc_fall = (lp_s_r != lp_p_r) && (lp_s_r[1] == lp_s_r[0]);
	assign line.esc_clk = esc_clk_r;
	assign line.byte_rise = bclk_r[1] & ~bclk_r[2];
	assign line.sot_soft = misc_s_r[0];
	assign line.sot_sync = misc_s_r[1];
	assign line.force_lvl = misc_s_r[2];
	assign line.lock_lvl = misc_s_r[3];
endmodule

//--- tb/drxl_proto_model.sv
// protocol side model: takes escape bytes on the escape clock and syncs the lane flags
`timescale 1ns/1ns
module drxl_proto_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic esc_clk,
	input wire logic esc_valid,
	input wire logic [7:0] esc_data,
	input wire logic ulps_active,
	input wire logic [3:0] trigger,
	output logic [7:0] last_byte,
	output logic [7:0] byte_cnt,
	output logic ulps_s,
	output logic [3:0] trig_s
);
	logic ulps_m;
	logic [3:0] trig_m;
	initial begin
		last_byte = 8'h00;
		byte_cnt = 8'h00;
	end
	// no back-pressure path, so a valid byte missed at this edge is gone
	always @(posedge esc_clk) begin
		if (esc_valid === 1'b1) begin
			last_byte <= esc_data;
			byte_cnt <= byte_cnt + 8'h01;
		end
	end
	// flags are async to our clock, two flops before use
	always @(posedge clock) begin
		ulps_m <= rstn ? ulps_active : 1'b0;
		ulps_s <= ulps_m;
		trig_m <= rstn ? trigger : 4'h0;
		trig_s <= trig_m;
	end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the receive lane: bus, escape traffic, errors, resets
`timescale 1ns/1ns
module tb_top;
	import drxl_pkg::*;
	localparam int INIT_N = 20;
	logic clock = 0, rstn = 0, core_rst = 0, hsel = 0, hwrite = 0, byte_clk = 0, bclk_on = 0;
	logic lp_dp = 1, lp_dn = 1, sot_soft_in = 0, sot_sync_in = 0, force_reinit = 0, system_rst_in = 0, lock_in = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = HSIZE_WORD;
	logic hreadyout, hresp, esc_clk, lpdt_active, ulps_active, esc_valid, err_sot_soft, err_sot_sync;
	logic err_esc_entry, err_esc_sync, err_control, system_rst_out, lock_out, init_done, ulps_s;
	logic [3:0] trigger, trig_s;
	logic [7:0] esc_data, last_byte, byte_cnt;
	logic [7:0] tcmd [3] = '{CMD_TRIG_RESET, CMD_TRIG_UNK3, CMD_TRIG_UNK5};
	logic [3:0] texp [3] = '{4'h1, 4'h4, 4'h8};
	wire hready = hreadyout;
	int bad_count = 0, cmp_count = 0, cnt;

	drxl_lane_rx #(.INIT_CYCLES(INIT_N)) i_dut (.clock(clock), .rstn(rstn), .core_rst(core_rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lp_dp(lp_dp), .lp_dn(lp_dn),
		.byte_clk(byte_clk), .sot_soft_in(sot_soft_in), .sot_sync_in(sot_sync_in), .force_reinit(force_reinit),
		.system_rst_in(system_rst_in), .lock_in(lock_in), .esc_clk(esc_clk), .lpdt_active(lpdt_active),
		.ulps_active(ulps_active), .trigger(trigger), .esc_data(esc_data), .esc_valid(esc_valid),
		.err_sot_soft(err_sot_soft), .err_sot_sync(err_sot_sync), .err_esc_entry(err_esc_entry),
		.err_esc_sync(err_esc_sync), .err_control(err_control), .system_rst_out(system_rst_out),
		.lock_out(lock_out), .init_done(init_done));
	drxl_proto_model i_model (.clock(clock), .rstn(rstn), .esc_clk(esc_clk), .esc_valid(esc_valid),
		.esc_data(esc_data), .ulps_active(ulps_active), .trigger(trigger), .last_byte(last_byte),
		.byte_cnt(byte_cnt), .ulps_s(ulps_s), .trig_s(trig_s));

	always #5 clock = ~clock;
	// byte clock stands low outside high-speed bursts, phase unrelated to clock
	initial begin
		#3;
		forever #40 byte_clk = bclk_on ? ~byte_clk : 1'b0;
	end
	initial begin
		#300000;
		bad_count++;
		end_sim();
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		// only the watchdog ends a stuck wait
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 0, hresp);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] x;
		ahb(1'b1, a, wd, x);
	endtask
	task automatic ln(input logic [1:0] s);
		{lp_dp, lp_dn} <= s;
		tick(6);
	endtask
	task automatic bit_tx(input logic b);
		ln(b ? LP_PREQ : LP_NREQ);
		chk("esc_clk_hi", 1, esc_clk);
		ln(LP_BRIDGE);
		chk("esc_clk_lo", 0, esc_clk);
	endtask
	task automatic byte_tx(input logic [7:0] v);
		for (int i = 0; i < 8; i++) bit_tx(v[i]);
	endtask
	task automatic entry();
		ln(LP_PREQ);
		ln(LP_BRIDGE);
		ln(LP_NREQ);
		ln(LP_BRIDGE);
	endtask
	task automatic wait_init();
		int n;
		tick(18);
		chk("init_early", 0, init_done);
		n = 0;
		while (init_done !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		chk("init_done", 1, init_done);
	endtask
	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		// look only once the first reset edge has settled the flops
		tick(2);
		chk("rst_hready", 1, hreadyout);
		chk("rst_sysrst", 1, system_rst_out);
		rstn <= 1'b1;
		wait_init();
		chk("sysrst_out", 0, system_rst_out);
		chk("lock_out", 1, lock_out);
		done("reset");
		ahb(1'b0, REG_CTRL_OFF, 0, d);
		chk("ctrl_rst", CTRL_RESET, d);
		wr(REG_STATUS_OFF, 32'hffffffff);
		ahb(1'b0, REG_STATUS_OFF, 0, d);
		chk("status_idle", 32'h00001c01, d);
		wr(32'h0000000c, 32'hffffffff);
		ahb(1'b0, 32'h0000000c, 0, d);
		chk("unmapped", 0, d);
		wr(REG_CTRL_OFF, 32'h00000003);
		ahb(1'b0, REG_CTRL_OFF, 0, d);
		chk("ctrl_rw", 32'h00000003, d);
		chk("init_forced", 0, init_done);
		wr(REG_CTRL_OFF, CTRL_RESET);
		wait_init();
		done("registers");
		entry();
		byte_tx(CMD_LPDT);
		chk("lpdt_on", 1, lpdt_active);
		byte_tx(8'h1e);
		chk("valid", 1, esc_valid);
		chk("data1", 8'h1e, esc_data);
		byte_tx(8'h35);
		chk("model_b1", 8'h1e, last_byte);
		ln(LP_PREQ);
		chk("model_b2", 8'h35, last_byte);
		chk("model_cnt", 2, byte_cnt);
		chk("lpdt_hold", 1, lpdt_active);
		ln(LP_STOP);
		chk("lpdt_off", 0, lpdt_active);
		chk("valid_off", 0, esc_valid);
		ahb(1'b0, REG_DATA_OFF, 0, d);
		chk("data_reg", 32'h00000035, d);
		done("lpdt");
		entry();
		byte_tx(CMD_LPDT);
		bit_tx(1'b1);
		bit_tx(1'b0);
		bit_tx(1'b1);
		ln(LP_PREQ);
		ln(LP_STOP);
		chk("sync_err", 1, err_esc_sync);
		chk("sync_cnt", 2, byte_cnt);
		done("esc_sync");
		ln(LP_PREQ);
		chk("sync_clr", 0, err_esc_sync);
		ln(LP_BRIDGE);
		ln(LP_NREQ);
		ln(LP_BRIDGE);
		byte_tx(8'hff);
		chk("entry_err", 1, err_esc_entry);
		ln(LP_PREQ);
		chk("entry_clr", 0, err_esc_entry);
		ln(LP_STOP);
		done("esc_entry");
		ln(LP_PREQ);
		ln(LP_BRIDGE);
		ln(LP_PREQ);
		ln(LP_STOP);
		chk("turn_err", 1, err_control);
		ln(LP_NREQ);
		chk("turn_clr", 0, err_control);
		ln(LP_STOP);
		chk("hs_err", 1, err_control);
		ln(LP_PREQ);
		ln(LP_STOP);
		chk("ctrl_err", 1, err_control);
		tick(10);
		chk("ctrl_hold", 1, err_control);
		ln(LP_PREQ);
		chk("ctrl_clr", 0, err_control);
		ln(LP_BRIDGE);
		ln(LP_NREQ);
		ln(LP_BRIDGE);
		byte_tx(CMD_ULPS);
		chk("ulps_on", 1, ulps_active);
		chk("ulps_sync", 1, ulps_s);
		ln(LP_PREQ);
		chk("ulps_hold", 1, ulps_active);
		ln(LP_STOP);
		chk("ulps_off", 0, ulps_active);
		done("control_ulps");
		for (int i = 0; i < 3; i++) begin
			entry();
			byte_tx(tcmd[i]);
			chk("trig", texp[i], trigger);
			ahb(1'b0, REG_STATUS_OFF, 0, d);
			chk("status_trig", texp[i], (d >> 3) & 32'hf);
			chk("trig_sync", texp[i], trig_s);
			ln(LP_PREQ);
			chk("trig_hold", texp[i], trigger);
			ln(LP_STOP);
			chk("trig_off", 0, trigger);
		end
		done("triggers");
		bclk_on = 1'b1;
		for (int k = 0; k < 2; k++) begin
			tick(8);
			cnt = 0;
			for (int i = 0; i < 48; i++) begin
				if (i == 0 && k == 0) sot_soft_in <= 1'b1;
				if (i == 0 && k == 1) sot_sync_in <= 1'b1;
				if (i == 8) {sot_soft_in, sot_sync_in} <= 2'b00;
				tick(1);
				cnt += ((k ? err_sot_sync : err_sot_soft) === 1'b1);
				if ((k ? err_sot_soft : err_sot_sync) !== 1'b0) cnt += 100;
			end
			chk("sot_len", 1, cnt >= 7 && cnt <= 9);
		end
		bclk_on = 1'b0;
		done("sot");
		force_reinit <= 1'b1;
		tick(6);
		chk("force_clr", 0, init_done);
		force_reinit <= 1'b0;
		wait_init();
		done("force");
		wr(REG_CTRL_OFF, 32'h00000000);
		tick(4);
		chk("ext_sysrst", 0, system_rst_out);
		chk("ext_lock", 0, lock_out);
		system_rst_in <= 1'b1;
		tick(4);
		chk("ext_rst_clr", 0, init_done);
		system_rst_in <= 1'b0;
		wait_init();
		wr(REG_CTRL_OFF, CTRL_RESET);
		core_rst <= 1'b1;
		tick(2);
		chk("core_rst_out", 1, system_rst_out);
		chk("core_rst_init", 0, init_done);
		core_rst <= 1'b0;
		wait_init();
		done("resets");
		end_sim();
	end
endmodule
